// ==== inc/gpio_dyn_cfg_pkg.sv ====
// shared constants and types for the line and dynamic control register bank
package gpio_dyn_cfg_pkg;
	localparam int DATA_W = 8;
	localparam int TEMP_W = 8;
	localparam int NUM_LINES = 8;
	localparam int LINES_PER_REG = 4;

	// register offsets
	localparam logic [7:0] IO_LINE_CONFIG_LOW_OFS = 8'h09;
	localparam logic [7:0] IO_LINE_CONFIG_HIGH_OFS = 8'h0a;
	localparam logic [7:0] DYNAMIC_MIN_TEMP_CONTROL_A_OFS = 8'h0b;

	// reset values
	localparam logic [7:0] IO_LINE_CONFIG_RST = 8'h00;
	localparam logic [7:0] DYNAMIC_MIN_TEMP_CONTROL_A_RST = 8'h00;
	localparam logic [7:0] UNMAPPED_READ_VAL = 8'h00;

	// field positions of the dynamic control register
	localparam int CHAN_A_DYN_EN_POS = 0;
	localparam int CHAN_B_DYN_EN_POS = 1;
	localparam int PIN_A_COPIES_CHAN_A_POS = 2;
	localparam int PIN_A_COPIES_CHAN_B_POS = 3;
	localparam int PIN_B_COPIES_CHAN_A_POS = 4;
	localparam int PIN_B_COPIES_CHAN_B_POS = 5;

	// encodings of the line fields
	localparam logic POLARITY_ACTIVE_LOW = 1'b0;
	localparam logic POLARITY_ACTIVE_HIGH = 1'b1;
	localparam logic DIRECTION_INPUT = 1'b0;
	localparam logic DIRECTION_OUTPUT = 1'b1;

	// thermal pins idle high, asserted low
	localparam logic THERMAL_PIN_IDLE = 1'b1;

	// one line: polarity in the even bit, direction in the odd bit above it
	typedef struct packed {
		logic direction;
		logic polarity;
	} line_cfg_t;

	typedef struct packed {
		logic [1:0] reserved;
		logic pin_b_copies_chan_b;
		logic pin_b_copies_chan_a;
		logic pin_a_copies_chan_b;
		logic pin_a_copies_chan_a;
		logic chan_b_dyn_en;
		logic chan_a_dyn_en;
	} dyn_ctrl_t;

	// register write request
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;

	// copy request toward one operating-point register
	typedef struct packed {
		logic valid;
		logic [TEMP_W-1:0] value;
	} op_copy_t;
endpackage

// ==== verilog/gpio_and_dyn_fan_start_temperature_config.sv ====
// line configuration and dynamic fan-start-temperature control register bank
`timescale 1ns/1ps

module gpio_and_dyn_fan_start_temperature_config
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic sw_rst_i,
	// register access
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic lock_i,
	// line pins and user side
	input wire logic line_enable_i,
	input wire logic [7:0] line_in_i,
	output logic [7:0] line_out_o,
	output logic [7:0] line_oe_o,
	input wire logic [7:0] line_drive_i,
	output logic [7:0] line_asserted_o,
	// thermal alert pins, active low
	input wire logic thermal_alert_pin_a_n_i,
	input wire logic thermal_alert_pin_b_n_i,
	// remote channel temperatures and operating points
	input wire logic [7:0] chan_a_temp_i,
	input wire logic [7:0] chan_a_op_i,
	input wire logic [7:0] chan_b_temp_i,
	input wire logic [7:0] chan_b_op_i,
	// operating-point copy requests and dynamic enables
	output logic chan_a_copy_o,
	output logic [7:0] chan_a_copy_val_o,
	output logic chan_b_copy_o,
	output logic [7:0] chan_b_copy_val_o,
	output logic chan_a_dyn_en_o,
	output logic chan_b_dyn_en_o
);
	gpio_dyn_cfg_pkg::line_cfg_t [gpio_dyn_cfg_pkg::NUM_LINES-1:0] cfg_q;
	gpio_dyn_cfg_pkg::dyn_ctrl_t dyn_q;
	gpio_dyn_cfg_pkg::reg_req_t req;
	gpio_dyn_cfg_pkg::op_copy_t copy_a_d;
	gpio_dyn_cfg_pkg::op_copy_t copy_b_d;
	logic wr_ok;
	logic pin_a_prev_q;
	logic pin_b_prev_q;
	logic pin_a_fall;
	logic pin_b_fall;
	logic want_a;
	logic want_b;
	logic pol0;

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction

	assign req.wr = reg_wr_i;
	assign req.addr = reg_addr_i;
	assign req.wdata = reg_wdata_i;
	// a locked bank silently drops writes; reads still work
	assign wr_ok = req.wr & ~lock_i;
	assign pol0 = cfg_q[0].polarity;

	// line configuration storage
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i || sw_rst_i)
		begin
			cfg_q <= {gpio_dyn_cfg_pkg::IO_LINE_CONFIG_RST,
				gpio_dyn_cfg_pkg::IO_LINE_CONFIG_RST};
		end
		else if (wr_ok && hit(req.addr, gpio_dyn_cfg_pkg::IO_LINE_CONFIG_LOW_OFS))
		begin
			cfg_q[3:0] <= req.wdata;
		end
		else if (wr_ok && hit(req.addr, gpio_dyn_cfg_pkg::IO_LINE_CONFIG_HIGH_OFS))
		begin
			cfg_q[7:4] <= req.wdata;
		end
	end

	// dynamic control storage, reserved bits kept as plain storage
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i || sw_rst_i)
		begin
			dyn_q <= gpio_dyn_cfg_pkg::DYNAMIC_MIN_TEMP_CONTROL_A_RST;
		end
		else if (wr_ok && hit(req.addr, gpio_dyn_cfg_pkg::DYNAMIC_MIN_TEMP_CONTROL_A_OFS))
		begin
			dyn_q <= req.wdata;
		end
	end

	// read data, registered; unmapped offsets read as zero
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			reg_rdata_o <= gpio_dyn_cfg_pkg::UNMAPPED_READ_VAL;
		end
		else if (hit(req.addr, gpio_dyn_cfg_pkg::IO_LINE_CONFIG_LOW_OFS))
		begin
			reg_rdata_o <= cfg_q[3:0];
		end
		else if (hit(req.addr, gpio_dyn_cfg_pkg::IO_LINE_CONFIG_HIGH_OFS))
		begin
			reg_rdata_o <= cfg_q[7:4];
		end
		else if (hit(req.addr, gpio_dyn_cfg_pkg::DYNAMIC_MIN_TEMP_CONTROL_A_OFS))
		begin
			reg_rdata_o <= dyn_q;
		end
		else
		begin
			reg_rdata_o <= gpio_dyn_cfg_pkg::UNMAPPED_READ_VAL;
		end
	end

	// line pin logic, one slice per line
	genvar k;
	generate
		for (k = 0; k < gpio_dyn_cfg_pkg::NUM_LINES; k++)
		begin : g_line
			always_ff @(posedge ref_clk_i)
			begin
				if (sys_rst_i)
				begin
					line_oe_o[k] <= 1'b0;
					line_out_o[k] <= 1'b0;
					line_asserted_o[k] <= 1'b0;
				end
				else
				begin
					line_oe_o[k] <= line_enable_i &
						(cfg_q[k].direction == gpio_dyn_cfg_pkg::DIRECTION_OUTPUT);
					line_out_o[k] <= line_enable_i & cfg_q[k].direction &
						(line_drive_i[k] ? cfg_q[k].polarity : ~cfg_q[k].polarity);
					line_asserted_o[k] <= line_enable_i &
						(cfg_q[k].direction == gpio_dyn_cfg_pkg::DIRECTION_INPUT) &
						(line_in_i[k] == cfg_q[k].polarity);
				end
			end
		end
	endgenerate

	// thermal pin assertion edges; one copy per assertion, not per cycle held
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			pin_a_prev_q <= gpio_dyn_cfg_pkg::THERMAL_PIN_IDLE;
			pin_b_prev_q <= gpio_dyn_cfg_pkg::THERMAL_PIN_IDLE;
		end
		else
		begin
			pin_a_prev_q <= thermal_alert_pin_a_n_i;
			pin_b_prev_q <= thermal_alert_pin_b_n_i;
		end
	end

	assign pin_a_fall = pin_a_prev_q & ~thermal_alert_pin_a_n_i;
	assign pin_b_fall = pin_b_prev_q & ~thermal_alert_pin_b_n_i;
	assign want_a = (pin_a_fall & dyn_q.pin_a_copies_chan_a) |
		(pin_b_fall & dyn_q.pin_b_copies_chan_a);
	assign want_b = (pin_a_fall & dyn_q.pin_a_copies_chan_b) |
		(pin_b_fall & dyn_q.pin_b_copies_chan_b);

	always_comb
	begin
		copy_a_d.valid = want_a & (chan_a_temp_i < chan_a_op_i);
		copy_a_d.value = chan_a_temp_i;
		copy_b_d.valid = want_b & (chan_b_temp_i < chan_b_op_i);
		copy_b_d.value = chan_b_temp_i;
	end

	// copy requests toward the operating-point registers
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			chan_a_copy_o <= 1'b0;
			chan_a_copy_val_o <= 8'h00;
			chan_b_copy_o <= 1'b0;
			chan_b_copy_val_o <= 8'h00;
		end
		else
		begin
			chan_a_copy_o <= copy_a_d.valid;
			chan_b_copy_o <= copy_b_d.valid;
			if (copy_a_d.valid)
			begin
				chan_a_copy_val_o <= copy_a_d.value;
			end
			if (copy_b_d.valid)
			begin
				chan_b_copy_val_o <= copy_b_d.value;
			end
		end
	end

	// dynamic control enables toward the fan loop
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			chan_a_dyn_en_o <= 1'b0;
			chan_b_dyn_en_o <= 1'b0;
		end
		else
		begin
			chan_a_dyn_en_o <= dyn_q.chan_a_dyn_en;
			chan_b_dyn_en_o <= dyn_q.chan_b_dyn_en;
		end
	end

	AST_LOW_WRITE: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(wr_ok && !sw_rst_i && reg_addr_i == gpio_dyn_cfg_pkg::IO_LINE_CONFIG_LOW_OFS)
		|=> ##1 $past(reg_addr_i) != gpio_dyn_cfg_pkg::IO_LINE_CONFIG_LOW_OFS
		|| reg_rdata_o == $past(reg_wdata_i, 2) || $past(reg_wr_i) || $past(sw_rst_i))
		else $error("low config write not read back");

	AST_HIGH_WRITE: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(wr_ok && !sw_rst_i && reg_addr_i == gpio_dyn_cfg_pkg::IO_LINE_CONFIG_HIGH_OFS)
		|=> cfg_q[7:4] == $past(reg_wdata_i))
		else $error("high config write lost");

	AST_LOCK_HOLDS: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(reg_wr_i && lock_i && !sw_rst_i) |=> $stable(cfg_q) && $stable(dyn_q))
		else $error("write changed a locked register");

	AST_SWRST_CLEARS: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		sw_rst_i |=> cfg_q == 16'h0000 && dyn_q == 8'h00 ##1 line_oe_o == 8'h00)
		else $error("software reset did not clear bank");

	AST_GATE_OFF: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!line_enable_i |=> line_oe_o == 8'h00 && line_asserted_o == 8'h00
		&& line_out_o == 8'h00)
		else $error("lines active while disabled");

	AST_OUT_LEVEL: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		line_oe_o[0] |-> line_out_o[0] ==
		($past(line_drive_i[0]) ? $past(pol0) : !$past(pol0)))
		else $error("output line drives wrong level");

	AST_COPY_A_FIRES: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(pin_a_fall && dyn_q.pin_a_copies_chan_a && chan_a_temp_i < chan_a_op_i)
		|=> chan_a_copy_o && chan_a_copy_val_o == $past(chan_a_temp_i))
		else $error("pin a copy to channel a missing");

	AST_COPY_B_FROM_PIN_B: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(pin_b_fall && dyn_q.pin_b_copies_chan_b && chan_b_temp_i < chan_b_op_i)
		|=> chan_b_copy_o && chan_b_copy_val_o == $past(chan_b_temp_i))
		else $error("pin b copy to channel b missing");

	AST_COPY_ONLY_LOWER: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		chan_a_copy_o |-> $past(chan_a_temp_i) < $past(chan_a_op_i))
		else $error("copy without a lower temperature");

	AST_COPY_DISABLED: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!(dyn_q.pin_a_copies_chan_b || dyn_q.pin_b_copies_chan_b) |=> !chan_b_copy_o)
		else $error("channel b copied while disabled");

	AST_DYN_EN_A: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(wr_ok && !sw_rst_i && reg_addr_i == gpio_dyn_cfg_pkg::DYNAMIC_MIN_TEMP_CONTROL_A_OFS)
		|-> ##2 chan_a_dyn_en_o == $past(reg_wdata_i[0], 2) || $past(sw_rst_i))
		else $error("channel a dynamic enable wrong");

	AST_DYN_EN_B: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		chan_b_dyn_en_o == $past(dyn_q.chan_b_dyn_en))
		else $error("channel b dynamic enable without its bit");

	AST_COPY_B_FROM_PIN_A: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(pin_a_fall && dyn_q.pin_a_copies_chan_b && chan_b_temp_i < chan_b_op_i)
		|=> chan_b_copy_o && chan_b_copy_val_o == $past(chan_b_temp_i))
		else $error("pin a copy to channel b missing");

	AST_COPY_A_FROM_PIN_B: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(pin_b_fall && dyn_q.pin_b_copies_chan_a && chan_a_temp_i < chan_a_op_i)
		|=> chan_a_copy_o && chan_a_copy_val_o == $past(chan_a_temp_i))
		else $error("pin b copy to channel a missing");

	AST_COPY_A_DISABLED: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!(dyn_q.pin_a_copies_chan_a || dyn_q.pin_b_copies_chan_a) |=> !chan_a_copy_o)
		else $error("channel a copied while disabled");

	// a pin held low must not keep rewriting the operating point
	AST_ONE_COPY_PER_ALERT: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		chan_a_copy_o |=> !chan_a_copy_o)
		else $error("channel a copy repeated without a new assertion");

	AST_RSVD_KEPT: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(wr_ok && !sw_rst_i && reg_addr_i == gpio_dyn_cfg_pkg::DYNAMIC_MIN_TEMP_CONTROL_A_OFS)
		|=> dyn_q.reserved == $past(reg_wdata_i[7:6]))
		else $error("reserved dynamic control bits not stored");
endmodule // gpio_and_dyn_fan_start_temperature_config

// ==== verif/thermal_partner.sv ====
// far-side model: thermal alert sources and the two operating-point registers
`timescale 1ns/1ps
module thermal_partner
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// bench commands: assert a pin, preload the operating points
	input wire logic [1:0] alert_i,
	input wire logic load_i,
	input wire logic [15:0] load_val_i,
	// copy requests from the device, index 0 channel a
	input wire logic [1:0] copy_i,
	input wire logic [15:0] copy_val_i,
	// pins and operating points
	output logic [1:0] pin_n_o,
	output logic [15:0] op_o
);
	// released pins float back to idle high through their pull-ups
	always_ff @(posedge ref_clk_i)
		pin_n_o <= sys_rst_i ? 2'b11 : ~alert_i;
	// a copy pulse overwrites the held operating point
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
			op_o <= 16'hffff;
		else if (load_i)
			op_o <= load_val_i;
		else
			for (int i = 0; i < 2; i++)
				if (copy_i[i])
					op_o[i*8 +: 8] <= copy_val_i[i*8 +: 8];
	end
endmodule // thermal_partner

// ==== verif/tb_top.sv ====
// register access, line and thermal copy testbench for the config bank
`timescale 1ns/1ps
module tb_top;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic sw_rst_i = 1'b0, reg_wr_i = 1'b0, lock_i = 1'b0, line_enable_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, line_in_i = 8'h00;
	logic [7:0] line_drive_i = 8'h00, chan_a_temp_i = 8'h00, chan_b_temp_i = 8'h00;
	logic [7:0] reg_rdata_o, line_out_o, line_oe_o, line_asserted_o;
	logic [7:0] chan_a_copy_val_o, chan_b_copy_val_o;
	logic chan_a_copy_o, chan_b_copy_o, chan_a_dyn_en_o, chan_b_dyn_en_o;
	logic [1:0] alert = 2'b00;
	logic [1:0] pin_n;
	logic load = 1'b0;
	logic [15:0] load_val = 16'h0000;
	logic [15:0] op;
	int fail_count = 0;
	int n_checks = 0;
	int n_copies = 0;

	always #10 ref_clk_i = ~ref_clk_i;

	// copy pulses seen, to prove one copy per pin assertion
	always @(posedge ref_clk_i)
		n_copies <= n_copies + int'(chan_a_copy_o) + int'(chan_b_copy_o);

	gpio_and_dyn_fan_start_temperature_config gpio_and_dyn_fan_start_temperature_config_i
	(
		.ref_clk_i, .sys_rst_i, .sw_rst_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
		.reg_rdata_o, .lock_i, .line_enable_i, .line_in_i, .line_out_o, .line_oe_o,
		.line_drive_i, .line_asserted_o,
		.thermal_alert_pin_a_n_i(pin_n[0]), .thermal_alert_pin_b_n_i(pin_n[1]),
		.chan_a_temp_i, .chan_a_op_i(op[7:0]), .chan_b_temp_i, .chan_b_op_i(op[15:8]),
		.chan_a_copy_o, .chan_a_copy_val_o, .chan_b_copy_o, .chan_b_copy_val_o,
		.chan_a_dyn_en_o, .chan_b_dyn_en_o
	);

	thermal_partner thermal_partner_i
	(
		.ref_clk_i, .sys_rst_i, .alert_i(alert), .load_i(load), .load_val_i(load_val),
		.copy_i({chan_b_copy_o, chan_a_copy_o}),
		.copy_val_i({chan_b_copy_val_o, chan_a_copy_val_o}),
		.pin_n_o(pin_n), .op_o(op)
	);

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask

	// read data lags the address by one edge; two edges leave margin
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		cyc(2);
		#1;
		chk(what, exp, reg_rdata_o);
	endtask

	// preload both operating points to 0x1e, pulse the pins, compare the result
	task automatic therm(input logic [7:0] ctl, input logic [1:0] pins,
		input logic [7:0] ta, input logic [7:0] tb, input logic [15:0] exp);
		int c0;
		wr(8'h0b, ctl);
		@(posedge ref_clk_i);
		load <= 1'b1;
		load_val <= 16'h1e1e;
		chan_a_temp_i <= ta;
		chan_b_temp_i <= tb;
		@(posedge ref_clk_i);
		load <= 1'b0;
		alert <= pins;
		c0 = n_copies;
		cyc(3);
		alert <= 2'b00;
		cyc(4);
		#1;
		chk("op_a", exp[7:0], op[7:0]);
		chk("op_b", exp[15:8], op[15:8]);
		chk("copies", {7'h00, exp[7:0] != 8'h1e} + {7'h00, exp[15:8] != 8'h1e},
			8'(n_copies - c0));
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		cyc(5);
		sys_rst_i <= 1'b0;
		rd(8'h09, 8'h00, "low_cfg_reset");
		rd(8'h0a, 8'h00, "high_cfg_reset");
		rd(8'h0b, 8'h00, "dyn_reset");
		rd(8'h0c, 8'h00, "unmapped");
		wr(8'h0b, 8'hc3);
		rd(8'h0b, 8'hc3, "dyn_readback");
		chk("dyn_en", 8'h03, {6'h00, chan_b_dyn_en_o, chan_a_dyn_en_o});
		wr(8'h0b, 8'h02);
		cyc(2);
		#1;
		chk("dyn_en_b", 8'h02, {6'h00, chan_b_dyn_en_o, chan_a_dyn_en_o});
		// locked write must leave the register untouched
		@(posedge ref_clk_i);
		lock_i <= 1'b1;
		wr(8'h09, 8'hff);
		lock_i <= 1'b0;
		rd(8'h09, 8'h00, "locked_write");
		// lines 1/5 out high, 2/6 out low, 3/7 in high, 4/8 in low
		wr(8'h09, 8'h1b);
		wr(8'h0a, 8'h1b);
		rd(8'h0a, 8'h1b, "high_cfg_readback");
		@(posedge ref_clk_i);
		line_drive_i <= 8'hff;
		line_in_i <= 8'h44;
		cyc(3);
		#1;
		chk("oe_disabled", 8'h00, line_oe_o);
		chk("asserted_disabled", 8'h00, line_asserted_o);
		@(posedge ref_clk_i);
		line_enable_i <= 1'b1;
		cyc(3);
		#1;
		chk("oe", 8'h33, line_oe_o);
		chk("out_driven", 8'h11, line_out_o);
		chk("asserted", 8'hcc, line_asserted_o);
		@(posedge ref_clk_i);
		line_drive_i <= 8'h00;
		cyc(3);
		#1;
		chk("out_idle", 8'h22, line_out_o);
		@(posedge ref_clk_i);
		sw_rst_i <= 1'b1;
		@(posedge ref_clk_i);
		sw_rst_i <= 1'b0;
		rd(8'h09, 8'h00, "sw_reset_low");
		rd(8'h0a, 8'h00, "sw_reset_high");
		rd(8'h0b, 8'h00, "sw_reset_dyn");
		chk("oe_after_sw_reset", 8'h00, line_oe_o);
		for (int k = 0; k < 4; k++)
			therm(8'h04 << k, (k < 2) ? 2'b01 : 2'b10, 8'h14, 8'h14,
				(k % 2 == 0) ? 16'h1e14 : 16'h141e);
		therm(8'h3c, 2'b11, 8'h1e, 8'h1f, 16'h1e1e);
		therm(8'h03, 2'b11, 8'h14, 8'h14, 16'h1e1e);
		final_report;
	end
endmodule // tb_top
